// *** logic/ao_cfg_pkg.sv ***
// Overview of operation
// - Eight channel select bits in config low byte, set means active, reset all set.
// - Four-channel build reads select bits four to seven as zero.
// - Three-bit span field: 0 2.5V, 1 5V, 2 10V, 3-7 reserved, resets 0.
// - Sync export bit drives clock and trigger onto external sync outputs.
// - Pacing source: 0 internal generator, 2 external clock input, others reserved.
// - Burst source: 0 internal generator, 2 external trigger input, others reserved.
// - Drive wiring bit: 0 single-ended, 1 differential, resets single-ended.
// - Polarity flip inverts external clock and trigger inputs and outputs only.
// - Generator and external clocks accepted only while pacing enable set; resets clear.
// - Read-only pacing accept flag shows whether a clock would act.
// - Soft pacing strobe makes one clock event, self-clears, mirrors board control.
// - Loop mode bit selects circular buffer when set, open when clear.
// - Refill granted rises at frame index zero with loop and request set; resets high.
// - Flush bit empties the buffer and self-clears when done.
// - Read-only empty flag resets one, full flag resets zero.
// - Fill-above-mark flag mirrors the threshold register flag.
// - Overrun set on write to full buffer, held until written zero.
// - Closed-write flag set on write to closed buffer, held until written zero.
// - Burst accept flag reads whether a trigger is honoured; separate burst enable.
// - Soft burst strobe makes one trigger, clears when triggered burst finishes.
// - Only active channels take data; inactive ones hold their last value.
// - A sample written to a full buffer is discarded and sets overrun.
package ao_cfg_pkg;
	localparam logic [7:0] ops_offset = 8'h3c;
	localparam logic [7:0] cfg_offset = 8'h54;
	localparam logic [31:0] ops_reset = 32'h0000_1400;
	localparam logic [31:0] cfg_reset = 32'h0000_00ff;
	localparam logic [31:0] cfg_rw_mask = 32'h0007_ffff;
	// Configuration fields
	localparam int cfg_span_lo = 8;
	localparam int cfg_span_w = 3;
	localparam int cfg_export_bit = 11;
	localparam int cfg_pace_src_lo = 12;
	localparam int cfg_burst_src_lo = 14;
	localparam int cfg_src_w = 2;
	localparam int cfg_diff_bit = 16;
	localparam int cfg_flip_bit = 17;
	localparam int cfg_maint_bit = 18;
	// Operations fields
	localparam int ops_pace_en_bit = 5;
	localparam int ops_pace_ok_bit = 6;
	localparam int ops_soft_pace_bit = 7;
	localparam int ops_loop_bit = 8;
	localparam int ops_refill_req_bit = 9;
	localparam int ops_refill_ok_bit = 10;
	localparam int ops_flush_bit = 11;
	localparam int ops_vacant_bit = 12;
	localparam int ops_mark_bit = 13;
	localparam int ops_saturated_bit = 15;
	localparam int ops_overrun_bit = 16;
	localparam int ops_closed_bit = 17;
	localparam int ops_burst_ok_bit = 18;
	localparam int ops_burst_en_bit = 19;
	localparam int ops_soft_burst_bit = 20;
	// Source codes
	localparam logic [1:0] src_internal = 2'h0;
	localparam logic [1:0] src_external = 2'h2;
	localparam int channels = 8;
	localparam int sample_w = 18;
endpackage : ao_cfg_pkg

// *** logic/ao_cfg_regs.sv ***
`timescale 1ns/1ps
// Output configuration and buffered-operations control registers
module ao_cfg_regs
	import ao_cfg_pkg::*;
#(
	parameter int channel_count = 8,
	parameter int store_depth_w = 18
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic board_pace_strobe,
	input wire logic board_burst_strobe,
	input wire logic rate_pace_tick,
	input wire logic rate_burst_tick,
	input wire logic ext_clock_pin,
	input wire logic ext_trigger_pin,
	input wire logic frame_index_zero,
	input wire logic refill_done,
	input wire logic burst_done,
	input wire logic mark_flag,
	input wire logic store_write,
	input wire logic store_closed,
	input wire logic [store_depth_w:0] store_count,
	input wire logic [store_depth_w:0] store_capacity,
	input wire logic [sample_w:0] src_data,
	input wire logic src_valid,
	output logic src_ready,
	output logic [channels-1:0][sample_w-1:0] chan_value,
	output logic ext_clock_out,
	output logic ext_clock_oe,
	output logic ext_trigger_out,
	output logic ext_trigger_oe,
	output logic [cfg_span_w-1:0] span_code,
	output logic diff_drive,
	output logic out_clock,
	output logic out_trigger,
	output logic store_flush
);
	typedef struct packed {
		logic [31:0] cfg_reg;
		logic [31:0] ops_reg;
		logic [31:0] rdata_reg;
		logic [2:0] chan_reg;
		logic [channels-1:0][sample_w-1:0] val_reg;
		logic clk_out_reg;
		logic clk_oe_reg;
		logic trg_out_reg;
		logic trg_oe_reg;
		logic pace_reg;
		logic burst_reg;
		logic flush_reg;
		logic burst_busy_reg;
		logic clk_prev_reg;
		logic trg_prev_reg;
	} state_type;
	state_type st_reg;
	state_type st_next;
	logic ext_clk_s;
	logic ext_trg_s;
	logic [sample_w:0] buf_data;
	logic buf_valid;
	logic buf_ready;
	logic vacant;
	logic saturated;
	logic [2:0] cur_chan;
	logic clk_edge;
	logic trg_edge;
	// Reserved low bits of the operations word end where pacing enable starts
	localparam int rsvd_w = ops_pace_en_bit;
	localparam logic [2:0] last_chan = 3'(channels - 1);

	// Pin inputs cross through two flops
	sync_in #(.width(2)) pin_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.pin({ext_clock_pin, ext_trigger_pin}),
		.level({ext_clk_s, ext_trg_s})
	);

	// Two entries absorb a stall while a clock is awaited
	skid_buf #(.width(sample_w + 1)) stage (
		.mclk(mclk),
		.rst_b(rst_b),
		.flush(st_reg.flush_reg),
		.in_data(src_data),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	// Next active channel after cur, wrapping
	function automatic logic [2:0] next_active(input logic [2:0] cur, input logic [7:0] sel);
		logic [2:0] idx;
		logic [2:0] res;
		res = cur;
		for (int i = 1; i <= channels; i++) begin
			idx = 3'(cur + 3'(i));
			if (sel[idx] && res == cur) begin
				res = idx;
			end
		end
		return res;
	endfunction : next_active

	// Pick a clock or trigger by source code; reserved codes give no event
	function automatic logic pick_src(input logic [1:0] code, input logic gen, input logic ext);
		logic r;
		r = 1'b0;
		if (code == src_internal) begin
			r = gen;
		end else if (code == src_external) begin
			r = ext;
		end
		return r;
	endfunction : pick_src

	// Active edge of a synced pin, falling when flipped
	// Edge, not level: a held pin gives one event, an idle inverted pin none
	function automatic logic pin_edge(input logic cur, input logic prev, input logic flip);
		return flip ? (prev && !cur) : (!prev && cur);
	endfunction : pin_edge

	assign vacant = (store_count == '0) && !buf_valid;
	assign saturated = (store_count >= store_capacity);

	logic [7:0] sel_eff;
	logic pace_ok;
	logic burst_ok;
	logic pace_evt;
	logic trig_evt;
	logic wr_cfg;
	logic wr_ops;
	logic flip;
	// Select bits beyond the build's channel count read as zero
	always_comb begin
		sel_eff = st_reg.cfg_reg[channels-1:0];
		for (int c = 0; c < channels; c++) begin
			if (c >= channel_count) begin
				sel_eff[c] = 1'b0;
			end
		end
	end
	assign flip = st_reg.cfg_reg[cfg_flip_bit];
	assign wr_cfg = reg_wr && (reg_addr == cfg_offset);
	assign wr_ops = reg_wr && (reg_addr == ops_offset);
	assign pace_ok = st_reg.ops_reg[ops_pace_en_bit] && buf_valid;
	assign burst_ok = st_reg.ops_reg[ops_burst_en_bit] && !st_reg.burst_busy_reg;
	// Soft strobe bypasses mode and enable
	assign clk_edge = pin_edge(ext_clk_s, st_reg.clk_prev_reg, flip);
	assign trg_edge = pin_edge(ext_trg_s, st_reg.trg_prev_reg, flip);
	assign pace_evt = st_reg.ops_reg[ops_soft_pace_bit] || (st_reg.ops_reg[ops_pace_en_bit]
		&& pick_src(st_reg.cfg_reg[cfg_pace_src_lo +: cfg_src_w], rate_pace_tick,
		clk_edge));
	assign trig_evt = (st_reg.ops_reg[ops_soft_burst_bit] && !st_reg.burst_busy_reg) || (burst_ok
		&& pick_src(st_reg.cfg_reg[cfg_burst_src_lo +: cfg_src_w], rate_burst_tick,
		trg_edge));
	// Current channel, moved on at once if it was just deselected so no word is lost
	assign cur_chan = sel_eff[st_reg.chan_reg] ? st_reg.chan_reg
		: next_active(st_reg.chan_reg, sel_eff);
	assign buf_ready = pace_evt;

	// Register update and status tracking
	always_comb begin
		st_next = st_reg;
		st_next.pace_reg = pace_evt && buf_valid;
		st_next.burst_reg = trig_evt;
		st_next.flush_reg = 1'b0;
		st_next.clk_prev_reg = ext_clk_s;
		st_next.trg_prev_reg = ext_trg_s;
		if (wr_cfg) begin
			st_next.cfg_reg = reg_wdata & cfg_rw_mask;
			st_next.cfg_reg[cfg_maint_bit] = 1'b0;
		end
		if (wr_ops) begin
			st_next.ops_reg[ops_pace_en_bit] = reg_wdata[ops_pace_en_bit];
			st_next.ops_reg[ops_loop_bit] = reg_wdata[ops_loop_bit];
			st_next.ops_reg[ops_burst_en_bit] = reg_wdata[ops_burst_en_bit];
			st_next.ops_reg[rsvd_w-1:0] = reg_wdata[rsvd_w-1:0];
			if (reg_wdata[ops_soft_pace_bit]) st_next.ops_reg[ops_soft_pace_bit] = 1'b1;
			if (reg_wdata[ops_refill_req_bit]) st_next.ops_reg[ops_refill_req_bit] = 1'b1;
			if (reg_wdata[ops_flush_bit]) st_next.ops_reg[ops_flush_bit] = 1'b1;
			if (reg_wdata[ops_soft_burst_bit]) st_next.ops_reg[ops_soft_burst_bit] = 1'b1;
			// Sticky flags clear only by writing zero
			if (!reg_wdata[ops_overrun_bit]) st_next.ops_reg[ops_overrun_bit] = 1'b0;
			if (!reg_wdata[ops_closed_bit]) st_next.ops_reg[ops_closed_bit] = 1'b0;
		end
		if (board_pace_strobe) st_next.ops_reg[ops_soft_pace_bit] = 1'b1;
		if (board_burst_strobe) st_next.ops_reg[ops_soft_burst_bit] = 1'b1;
		// Strobes self-clear once consumed
		if (st_reg.ops_reg[ops_soft_pace_bit]) st_next.ops_reg[ops_soft_pace_bit] = 1'b0;
		if (st_reg.ops_reg[ops_flush_bit]) begin
			st_next.ops_reg[ops_flush_bit] = 1'b0;
			st_next.flush_reg = 1'b1;
		end
		if (trig_evt) st_next.burst_busy_reg = 1'b1;
		if (burst_done && st_reg.burst_busy_reg) begin
			st_next.burst_busy_reg = 1'b0;
			st_next.ops_reg[ops_soft_burst_bit] = 1'b0;
		end
		if (refill_done) st_next.ops_reg[ops_refill_req_bit] = 1'b0;
		if (wr_ops && reg_wdata[ops_refill_req_bit]) begin
			st_next.ops_reg[ops_refill_ok_bit] = 1'b0;
		end
		if (frame_index_zero && st_reg.ops_reg[ops_loop_bit]
				&& st_reg.ops_reg[ops_refill_req_bit]) begin
			st_next.ops_reg[ops_refill_ok_bit] = 1'b1;
		end
		// Set beats clear for hardware events
		if (store_write && saturated) st_next.ops_reg[ops_overrun_bit] = 1'b1;
		if (store_write && store_closed) st_next.ops_reg[ops_closed_bit] = 1'b1;
		st_next.ops_reg[ops_pace_ok_bit] = pace_ok;
		st_next.ops_reg[ops_vacant_bit] = vacant;
		st_next.ops_reg[ops_saturated_bit] = saturated;
		st_next.ops_reg[ops_mark_bit] = mark_flag;
		st_next.ops_reg[ops_burst_ok_bit] = burst_ok;
		// Clocked word goes to the current active channel only; none active drops it
		st_next.chan_reg = cur_chan;
		if (pace_evt && buf_valid && sel_eff != '0) begin
			st_next.val_reg[cur_chan] = buf_data[sample_w-1:0];
			st_next.chan_reg = buf_data[sample_w] ? next_active(last_chan, sel_eff)
				: next_active(cur_chan, sel_eff);
		end
		// Exported sync, inverted when flipped
		st_next.clk_oe_reg = st_reg.cfg_reg[cfg_export_bit];
		st_next.trg_oe_reg = st_reg.cfg_reg[cfg_export_bit];
		st_next.clk_out_reg = st_reg.cfg_reg[cfg_export_bit] && (pace_evt ^ flip);
		st_next.trg_out_reg = st_reg.cfg_reg[cfg_export_bit] && (trig_evt ^ flip);
		st_next.rdata_reg = 32'h0;
		if (reg_rd && reg_addr == cfg_offset) begin
			st_next.rdata_reg = {st_reg.cfg_reg[31:8], sel_eff};
		end else if (reg_rd && reg_addr == ops_offset) begin
			st_next.rdata_reg = st_reg.ops_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.cfg_reg <= cfg_reset;
			st_reg.ops_reg <= ops_reset;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata_reg;
	assign chan_value = st_reg.val_reg;
	assign ext_clock_out = st_reg.clk_out_reg;
	assign ext_clock_oe = st_reg.clk_oe_reg;
	assign ext_trigger_out = st_reg.trg_out_reg;
	assign ext_trigger_oe = st_reg.trg_oe_reg;
	assign span_code = st_reg.cfg_reg[cfg_span_lo +: cfg_span_w];
	assign diff_drive = st_reg.cfg_reg[cfg_diff_bit];
	assign out_clock = st_reg.pace_reg;
	assign out_trigger = st_reg.burst_reg;
	assign store_flush = st_reg.flush_reg;
endmodule : ao_cfg_regs

// *** logic/skid_buf.sv ***
`timescale 1ns/1ps
// Two-entry buffer with valid/ready on both sides
module skid_buf
	import ao_cfg_pkg::*;
#(
	parameter int width = 19
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic [width-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [width-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	typedef struct packed {
		logic [1:0][width-1:0] mem_reg;
		logic rd_reg;
		logic wr_reg;
		logic [1:0] cnt_reg;
		logic ready_reg;
	} state_type;
	state_type st_reg;
	state_type st_next;
	logic push;
	logic pop;

	// Ready comes from a flop so the stall reaches the source without a comb path
	assign in_ready = st_reg.ready_reg;
	assign out_valid = (st_reg.cnt_reg != 2'h0);
	assign out_data = st_reg.mem_reg[st_reg.rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer ring; flush drops both entries
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem_reg[st_reg.wr_reg] = in_data;
			st_next.wr_reg = ~st_reg.wr_reg;
		end
		if (pop) begin
			st_next.rd_reg = ~st_reg.rd_reg;
		end
		st_next.cnt_reg = st_reg.cnt_reg + {1'b0, push} - {1'b0, pop};
		if (flush) begin
			st_next.rd_reg = 1'b0;
			st_next.wr_reg = 1'b0;
			st_next.cnt_reg = 2'h0;
		end
		st_next.ready_reg = (st_next.cnt_reg != 2'h2);
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule : skid_buf

// *** logic/sync_in.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module sync_in
	import ao_cfg_pkg::*;
#(
	parameter int width = 1
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [width-1:0] pin,
	output logic [width-1:0] level
);
	typedef struct packed {
		logic [width-1:0] first_reg;
		logic [width-1:0] second_reg;
	} state_type;
	state_type st_reg;
	state_type st_next;

	// First stage feeds only the second
	always_comb begin
		st_next = st_reg;
		st_next.first_reg = pin;
		st_next.second_reg = st_reg.first_reg;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.second_reg;
endmodule : sync_in

// *** testbench/analog_out_config_and_buffer_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module analog_out_config_and_buffer_control_tb;
	import ao_cfg_pkg::*;
	logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tick = 0, btick = 0;
	logic fz = 0, rdone = 0, bdone = 0, mark = 0, swr = 0, closed = 0, stall = 1;
	logic epin = 0, tpin = 0, bps = 0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [18:0] cnt = 19'h0, cap = 19'h4, src_data;
	logic src_valid, src_ready, eclk, eclk_oe, etrg, etrg_oe, diff, oclk, otrg, flush;
	logic [2:0] span;
	logic [channels-1:0][sample_w-1:0] chan;
	int failures = 0, num_checks = 0, nclk = 0, ntrg = 0, nfl = 0, taken;
	always #2.5 mclk = ~mclk;
	// One-cycle event pulses counted at the edge they stand on
	always @(posedge mclk) begin
		if (oclk === 1'b1) nclk++;
		if (otrg === 1'b1) ntrg++;
		if (flush === 1'b1) nfl++;
	end
	ao_cfg_regs dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata), .board_pace_strobe(bps),
		.board_burst_strobe(1'b0), .rate_pace_tick(tick), .rate_burst_tick(btick),
		.ext_clock_pin(epin), .ext_trigger_pin(tpin), .frame_index_zero(fz),
		.refill_done(rdone), .burst_done(bdone), .mark_flag(mark), .store_write(swr),
		.store_closed(closed), .store_count(cnt), .store_capacity(cap), .src_data(src_data),
		.src_valid(src_valid), .src_ready(src_ready), .chan_value(chan),
		.ext_clock_out(eclk), .ext_clock_oe(eclk_oe), .ext_trigger_out(etrg),
		.ext_trigger_oe(etrg_oe), .span_code(span), .diff_drive(diff), .out_clock(oclk),
		.out_trigger(otrg), .store_flush(flush));
	store_model far (.mclk(mclk), .rst_b(rst_b), .stall(stall), .src_ready(src_ready),
		.src_data(src_data), .src_valid(src_valid), .taken(taken));
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk) #1;
		addr = a;
		wdata = d;
		reg_wr = 1;
		@(posedge mclk) #1;
		reg_wr = 0;
	endtask : wr
	// Read answer lands in v one cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk) #1;
		addr = a;
		reg_rd = 1;
		@(posedge mclk) #1;
		reg_rd = 0;
		v = rdata;
	endtask : rd
	task automatic pulse(ref logic s);
		@(posedge mclk) #1;
		s = 1;
		@(posedge mclk) #1;
		s = 0;
	endtask : pulse
	task automatic t_reset;
		rd(ops_offset);
		`CHK(v, ops_reset)
		rd(cfg_offset);
		`CHK(v, cfg_reset)
		`CHK(diff, 1'b0)
		stall = 0;
	endtask : t_reset
	// Reserved bits written high on purpose; the maintenance bit kept low
	task automatic t_cfg;
		wr(cfg_offset, 32'hfffb_ffff);
		rd(cfg_offset);
		`CHK(v, 32'h0003_ffff)
		`CHK(diff, 1'b1)
		`CHK(eclk_oe, 1'b1)
		`CHK(eclk, 1'b1)
		for (int i = 0; i < 3; i++) begin
			wr(cfg_offset, 32'h0000_00ff | (i << cfg_span_lo));
			idle(2);
			`CHK(span, 3'(i))
		end
		`CHK(eclk_oe, 1'b0)
	endtask : t_cfg
	// Buffer holds two words while clocking is off, then feeds channel zero
	task automatic t_pace;
		`CHK(src_ready, 1'b0)
		wr(ops_offset, 32'h80);
		idle(3);
		`CHK(nclk, 1)
		`CHK(chan[0], 18'h100)
		rd(ops_offset);
		`CHK(v[ops_soft_pace_bit], 1'b0)
		pulse(tick);
		idle(3);
		`CHK(nclk, 1)
		wr(cfg_offset, 32'h01);
		wr(ops_offset, 32'h20);
		rd(ops_offset);
		`CHK(v[ops_pace_ok_bit], 1'b1)
		pulse(tick);
		pulse(tick);
		idle(3);
		`CHK(nclk, 3)
		`CHK(chan[0], 18'h102)
		`CHK(chan[1], 18'h0)
		wr(cfg_offset, 32'h2001);
		pulse(tick);
		idle(3);
		`CHK(nclk, 3)
		// External pin edge, then the falling edge once flipped
		pulse(epin);
		idle(4);
		`CHK(nclk, 4)
		`CHK(chan[0], 18'h103)
		wr(cfg_offset, 32'h2_2001);
		pulse(epin);
		idle(4);
		`CHK(nclk, 5)
		pulse(bps);
		idle(3);
		`CHK(nclk, 6)
		`CHK(chan[0], 18'h105)
		wr(ops_offset, 32'h0);
		rd(ops_offset);
		`CHK(v[ops_pace_ok_bit], 1'b0)
	endtask : t_pace
	task automatic t_flags;
		mark = 1;
		cnt = 19'h4;
		pulse(swr);
		rd(ops_offset);
		`CHK(v[16:15], 2'b11)
		`CHK(v[ops_mark_bit], 1'b1)
		wr(ops_offset, 32'h0);
		cnt = 19'h0;
		closed = 1;
		pulse(swr);
		closed = 0;
		rd(ops_offset);
		`CHK(v[17:15], 3'b100)
		wr(ops_offset, 32'h0);
		rd(ops_offset);
		`CHK(v[17], 1'b0)
	endtask : t_flags
	task automatic t_flush;
		wr(ops_offset, 32'h800);
		idle(4);
		`CHK(nfl, 1)
		rd(ops_offset);
		`CHK(v[ops_flush_bit], 1'b0)
	endtask : t_flush
	// Host raises the request before any reload
	task automatic t_refill;
		wr(ops_offset, 32'h300);
		rd(ops_offset);
		`CHK(v[10:8], 3'b011)
		pulse(fz);
		rd(ops_offset);
		`CHK(v[ops_refill_ok_bit], 1'b1)
		pulse(rdone);
		rd(ops_offset);
		`CHK(v[ops_refill_req_bit], 1'b0)
	endtask : t_refill
	task automatic t_burst;
		wr(ops_offset, 32'h8_0000);
		rd(ops_offset);
		`CHK(v[ops_burst_ok_bit], 1'b1)
		wr(ops_offset, 32'h18_0000);
		idle(3);
		`CHK(ntrg, 1)
		rd(ops_offset);
		`CHK(v[20:18], 3'b110)
		pulse(bdone);
		rd(ops_offset);
		`CHK(v[20:18], 3'b011)
		pulse(btick);
		idle(3);
		`CHK(ntrg, 2)
		pulse(bdone);
		wr(cfg_offset, 32'h80ff);
		pulse(btick);
		idle(3);
		`CHK(ntrg, 2)
		pulse(tpin);
		idle(4);
		`CHK(ntrg, 3)
	endtask : t_burst
	task automatic end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge mclk);
		#1 rst_b = 1;
		t_reset();
		t_cfg();
		t_pace();
		t_flags();
		t_flush();
		t_refill();
		t_burst();
		end_sim();
	end
	// Whole run is about 150 cycles; this cuts a hang short
	initial begin
		#100000;
		failures++;
		end_sim();
	end
endmodule : analog_out_config_and_buffer_control_tb

// *** testbench/ao_cfg_checker.sv ***
`timescale 1ns/1ps
// Port-level watch on the config and operations register block
module ao_cfg_checker
	import ao_cfg_pkg::*;
#(
	parameter int store_depth_w = 18
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic mark_flag,
	input wire logic store_write,
	input wire logic [store_depth_w:0] store_count,
	input wire logic [store_depth_w:0] store_capacity,
	input wire logic ext_clock_oe,
	input wire logic ext_trigger_oe,
	input wire logic [cfg_span_w-1:0] span_code,
	input wire logic out_clock,
	input wire logic out_trigger,
	input wire logic store_flush
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Write strobes decoded per register, read strobe for the operations register only
	wire logic cfg_wr = reg_wr && reg_addr == cfg_offset;
	wire logic ops_wr = reg_wr && reg_addr == ops_offset;
	wire logic ops_rd = reg_rd && reg_addr == ops_offset;
	wire logic full = store_count >= store_capacity;
	property p_oe_pair;
		ext_clock_oe == ext_trigger_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("sync enables differ");
	property p_oe_cause;
		$changed(ext_clock_oe) |-> $past(cfg_wr) || $past(cfg_wr, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("sync enable moved alone");
	// Written span seen once writes pause
	property p_span;
		cfg_wr ##1 !reg_wr ##1 !reg_wr |=>
			span_code == $past(reg_wdata[cfg_span_lo +: cfg_span_w], 3);
	endproperty
	a_span: assert property (p_span) else $error("span code not taken");
	property p_flush_pulse;
		store_flush |=> !store_flush;
	endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than one");
	property p_flush_cause;
		$rose(store_flush) |-> $past(ops_wr && reg_wdata[11]) ||
			$past(ops_wr && reg_wdata[11], 2) || $past(ops_wr && reg_wdata[11], 3);
	endproperty
	a_flush_cause: assert property (p_flush_cause) else $error("flush without write");
	property p_sat;
		full [*3] ##0 ops_rd |=> reg_rdata[15];
	endproperty
	a_sat: assert property (p_sat) else $error("full flag low");
	property p_mark;
		$stable(mark_flag) [*3] ##0 ops_rd |=> reg_rdata[13] == $past(mark_flag);
	endproperty
	a_mark: assert property (p_mark) else $error("mark flag not mirrored");
	property p_overrun;
		(store_write && full) ##1 !ops_wr ##1 ops_rd |=> reg_rdata[16];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not set");
	property p_cfg_hi;
		reg_rd && reg_addr == cfg_offset |=> reg_rdata[31:18] == 14'h0;
	endproperty
	a_cfg_hi: assert property (p_cfg_hi) else $error("config high bits set");
	c_clock: cover property (out_clock);
	c_trigger: cover property (out_trigger);
	c_flush: cover property (store_flush);
endmodule : ao_cfg_checker
bind ao_cfg_regs ao_cfg_checker #(.store_depth_w(store_depth_w)) chk (.mclk(mclk),
	.rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mark_flag(mark_flag),
	.store_write(store_write), .store_count(store_count), .store_capacity(store_capacity),
	.ext_clock_oe(ext_clock_oe), .ext_trigger_oe(ext_trigger_oe), .span_code(span_code),
	.out_clock(out_clock), .out_trigger(out_trigger), .store_flush(store_flush));

// *** testbench/store_model.sv ***
`timescale 1ns/1ps
// Sample store stand-in feeding numbered words
module store_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic stall,
	input wire logic src_ready,
	output logic [18:0] src_data,
	output logic src_valid,
	output int taken
);
	logic [18:0] word;
	assign word = 19'(taken + 256);
	// Off-valid cycles show the inverse so a stale capture shows up
	assign src_data = src_valid ? word : ~word;
	// Valid once raised holds until the word is taken
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			src_valid <= 1'b0;
			taken <= 0;
		end else if (src_valid && src_ready) begin
			taken <= taken + 1;
			src_valid <= !stall;
		end else if (!src_valid) begin
			src_valid <= !stall;
		end
	end
endmodule : store_model
